//--- design/monitor_out_pkg.sv
// constants and carrier types for the monitor pulse, analog drive and fault relay stage
// assumes one 200 MHz control clock
package monitor_out_pkg;
   localparam int unsigned CLK_HZ          = 200_000_000;
   localparam int unsigned MON_W           = 16;          // monitor amount, 0x8000 = 100 %
   localparam logic [15:0] MON_FULL        = 16'h8000;
   localparam logic [10:0] SEL_MAX         = 11'h00A;
   localparam logic [3:0]  SEL_POWER       = 4'h6;
   localparam logic [3:0]  SEL_UNIVERSAL   = 4'hA;
   localparam logic [12:0] RATE_MIN        = 13'h012C;    // 300 p/s
   localparam logic [12:0] RATE_MAX        = 13'h1770;    // 6000 p/s
   localparam logic [12:0] RATE_FIXED      = 13'h0A6E;    // 2670 p/s
   localparam logic [7:0]  PCT_MAX         = 8'hC8;       // 200 %
   localparam logic [7:0]  PCT_ZERO        = 8'h00;
   localparam logic [7:0]  PCT_FULL        = 8'h64;       // 100 %
   localparam int unsigned AO_W            = 12;          // analog drive code, full = 10 V
   localparam int unsigned SUPPLY_MS       = 1000;
   localparam int unsigned SUPPLY_CYCLES   = CLK_HZ / 1000 * SUPPLY_MS;
   localparam int unsigned PHASE_W         = 32;

   typedef struct packed {
      logic [3:0]  analog_select;
      logic [7:0]  analog_gain;
      logic [3:0]  pulse_select;
      logic [12:0] pulse_rate;
      logic [7:0]  pulse_avg;
      logic        relay_mode;
   } cfg_s;

   typedef struct packed {
      logic [PHASE_W-1:0] phase;
      logic [31:0]        supply_cnt;
      logic               supply_ok;
      logic               pulse;
      logic [AO_W-1:0]    analog;
      logic               relay;
   } state_s;
endpackage

//--- design/monitor_pulse_and_fault_relay_output.sv
// pulse monitor, analog monitor drive and fault relay output stage
// assumes settings and monitor amounts are synchronous to core_clk_i
//
// Summary of operation
// - the full-scale pulse rate is taken between 300 and 6000 p/s in 1 p/s steps.
// - with average-voltage setting 0 the rate follows the amount up to full scale at 50% duty.
// - with setting 1..200 the rate is 2670 p/s and duty gives the set average at full amount.
// - selector codes 0..10 pick one of eleven monitor amounts, each scaled to its own 100%.
// - the pulse output uses the same selector codes as the analog output, but takes no gain and scales the universal value like any other item.
// - power consumption reads zero while the load regenerates.
// - analog gain of 0..200% scales the analog drive at full amount, except the universal value, which takes no gain.
// - relay mode 0 excites the relay on fault, mode 1 excites it in normal running.
// - in mode 1 the relay is excited only after the supply settles, about one second.
// - with no power the relay is released, open contact open and closed contact closed.
`timescale 1ns/1ps
module monitor_pulse_and_fault_relay_output #(
   parameter int unsigned SUPPLY_CYCLES = monitor_out_pkg::SUPPLY_CYCLES
) (
   // clock and reset
   input  wire logic                          core_clk_i,
   input  wire logic                          rstn_i,
   // settings
   input  wire monitor_out_pkg::cfg_s         cfg_i,
   // monitor amounts, index = selector code; 0x8000 = 100 %, signed for power
   input  wire logic [10:0][15:0]             monitor_amount_i,
   input  wire logic                          regenerating_i,
   input  wire logic                          fault_i,
   // outputs
   output logic                               pulse_monitor_pin_o,
   output logic [monitor_out_pkg::AO_W-1:0]   analog_monitor_pin_o,
   output logic                               fault_relay_o
);
   monitor_out_pkg::state_s state_reg;
   monitor_out_pkg::state_s state_next;

   // ----------------------------------------
   // local constants
   // ----------------------------------------
   // accumulator width and its span; the span is one bit wider so that a
   // duty threshold of full span keeps the pulse high for the whole period
   localparam int unsigned ACC_W     = monitor_out_pkg::PHASE_W;
   localparam logic [32:0] ACC_SPAN  = 33'h1_0000_0000;
   localparam logic [32:0] HALF_SPAN = 33'h0_8000_0000;
   // analog drive codes for 10 V and for 100 % amount at 100 % gain
   localparam logic [32:0] AO_TOP    = 33'((1 << monitor_out_pkg::AO_W) - 1);
   localparam logic [32:0] AO_MID    = AO_TOP >> 1;
   // zero amount, zero step and one count of the supply timer
   localparam logic [15:0] AMT_ZERO  = 16'h0000;
   localparam logic [31:0] STEP_ZERO = 32'h0000_0000;
   localparam logic [31:0] CNT_ONE   = 32'h0000_0001;

   // ----------------------------------------
   // helper functions
   // ----------------------------------------
   // amount of one selector code; unknown codes read zero, regenerating or
   // negative power reads zero and anything above 100 % is held at 100 %
   function automatic logic [15:0] pick(input logic [3:0]        sel,
                                        input logic [10:0][15:0] amt,
                                        input logic              regen);
      logic [15:0] v;
      v = AMT_ZERO;
      if ({7'h00, sel} <= monitor_out_pkg::SEL_MAX) begin
         v = amt[sel];
      end
      if (sel == monitor_out_pkg::SEL_POWER) begin
         if (regen || (v[15] && v != monitor_out_pkg::MON_FULL)) begin
            v = AMT_ZERO;
         end
      end
      if (v > monitor_out_pkg::MON_FULL) begin
         v = monitor_out_pkg::MON_FULL;
      end
      return v;
   endfunction

   // percent settings above 200 % are held at 200 %
   function automatic logic [7:0] clamp_pct(input logic [7:0] pct);
      logic [7:0] r;
      r = pct;
      if (pct > monitor_out_pkg::PCT_MAX) begin
         r = monitor_out_pkg::PCT_MAX;
      end
      return r;
   endfunction

   // the full-scale rate is kept inside its legal band
   function automatic logic [12:0] clamp_rate(input logic [12:0] rate);
      logic [12:0] r;
      r = rate;
      if (rate < monitor_out_pkg::RATE_MIN) begin
         r = monitor_out_pkg::RATE_MIN;
      end
      if (rate > monitor_out_pkg::RATE_MAX) begin
         r = monitor_out_pkg::RATE_MAX;
      end
      return r;
   endfunction

   // amount times percent, as a share of a full-scale value
   function automatic logic [32:0] scale(input logic [15:0] amt,
                                         input logic [7:0]  pct,
                                         input logic [32:0] full);
      logic [63:0] p;
      logic [63:0] d;
      p = 64'(amt) * 64'(pct) * 64'(full);
      d = 64'(monitor_out_pkg::MON_FULL) * 64'(monitor_out_pkg::PCT_FULL);
      return 33'(p / d);
   endfunction

   // accumulator step per clock for a rate in pulses per second
   function automatic logic [31:0] phase_increment(input logic [32:0] rate);
      logic [63:0] num;
      num = 64'(rate) << ACC_W;
      return 32'(num / 64'(monitor_out_pkg::CLK_HZ));
   endfunction

   // ----------------------------------------
   // amount selection and pulse scaling
   // ----------------------------------------
   logic [15:0] analog_amt;
   logic [15:0] pulse_amt;
   logic [12:0] rate_set;
   logic [32:0] rate_now;
   logic [31:0] phase_step;
   logic [32:0] duty_thr;
   logic [32:0] ao_val;
   logic [31:0] phase_sum;
   logic        rate_mode;

   // the pulse runs in one of two modes: rate follows amount at half duty,
   // or a fixed rate whose duty follows amount times the average setting
   always_comb begin
      analog_amt = pick(cfg_i.analog_select, monitor_amount_i, regenerating_i);
      pulse_amt  = pick(cfg_i.pulse_select, monitor_amount_i, regenerating_i);
      rate_set   = clamp_rate(cfg_i.pulse_rate);
      rate_mode  = (cfg_i.pulse_avg == monitor_out_pkg::PCT_ZERO);
      if (rate_mode) begin
         rate_now = scale(pulse_amt, monitor_out_pkg::PCT_FULL, 33'(rate_set));
         duty_thr = HALF_SPAN;
      end else begin
         rate_now = 33'(monitor_out_pkg::RATE_FIXED);
         duty_thr = scale(pulse_amt, clamp_pct(cfg_i.pulse_avg), HALF_SPAN);
      end
      if (duty_thr > ACC_SPAN) begin
         duty_thr = ACC_SPAN;
      end
      phase_step = phase_increment(rate_now);
   end

   // ----------------------------------------
   // analog drive
   // ----------------------------------------
   // the universal value spans the whole code range and takes no gain;
   // every other item is scaled so 100 % at 100 % gain lands on mid-code
   always_comb begin
      if (cfg_i.analog_select == monitor_out_pkg::SEL_UNIVERSAL) begin
         ao_val = scale(analog_amt, monitor_out_pkg::PCT_FULL, AO_TOP);
      end else begin
         ao_val = scale(analog_amt, clamp_pct(cfg_i.analog_gain), AO_MID);
      end
      if (ao_val > AO_TOP) begin
         ao_val = AO_TOP;
      end
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      state_next       = state_reg;
      // the accumulator simply wraps; its carry is not needed
      phase_sum        = state_reg.phase + phase_step;
      state_next.phase = phase_sum;
      if (rate_mode) begin
         // high in the lower half of each turn; a zero step holds the line low
         state_next.pulse = (phase_step != STEP_ZERO) && !phase_sum[ACC_W-1];
      end else begin
         // full span compares true at every phase, so the line stays high
         state_next.pulse = ({1'b0, phase_sum} < duty_thr);
      end
      state_next.analog = ao_val[monitor_out_pkg::AO_W-1:0];
      // supply settle timer runs once after reset and then stops
      if (!state_reg.supply_ok) begin
         if (state_reg.supply_cnt >= 32'(SUPPLY_CYCLES - 1)) begin
            state_next.supply_ok = 1'b1;
         end else begin
            state_next.supply_cnt = state_reg.supply_cnt + CNT_ONE;
         end
      end
      // relay polarity; in mode 1 nothing excites before the supply settles
      if (cfg_i.relay_mode) begin
         state_next.relay = state_reg.supply_ok && !fault_i;
      end else begin
         state_next.relay = fault_i;
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   // reset leaves the relay released, the same rest state as with no power
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign pulse_monitor_pin_o  = state_reg.pulse;
   assign analog_monitor_pin_o = state_reg.analog;
   assign fault_relay_o        = state_reg.relay;
endmodule

//--- sim/monitor_out_props.sv
// assertions on the ports of the monitor output stage
// assumes one clock domain and the bind at the foot of this file
`timescale 1ns/1ps
module monitor_out_props #(
   parameter int unsigned SUPPLY_CYCLES = 20
) (
   input wire logic                                 core_clk_i,
   input wire logic                                 rstn_i,
   input wire monitor_out_pkg::cfg_s                cfg_i,
   input wire logic [10:0][15:0]                    monitor_amount_i,
   input wire logic                                 regenerating_i,
   input wire logic                                 fault_i,
   input wire logic                                 pulse_monitor_pin_o,
   input wire logic [monitor_out_pkg::AO_W-1:0]     analog_monitor_pin_o,
   input wire logic                                 fault_relay_o
);
   logic [31:0] up_reg;
   logic [15:0] pa;
   logic [15:0] aa;
   logic        full_d;
   logic        zero_d;
   logic        ao_z;
   logic        ao_f;
   logic        ao_u;
   assign pa = monitor_amount_i[cfg_i.pulse_select];
   assign aa = monitor_amount_i[cfg_i.analog_select];
   assign full_d = cfg_i.pulse_avg == 8'hC8 && pa >= 16'h8000 && cfg_i.pulse_select != 4'h6;
   assign zero_d = pa == 16'h0000 && cfg_i.pulse_avg != 8'h00;
   assign ao_z = (cfg_i.analog_gain == 8'h00 && cfg_i.analog_select != 4'hA)
                 || (cfg_i.analog_select == 4'h6 && regenerating_i);
   assign ao_f = aa == 16'h8000 && cfg_i.analog_select != 4'h6
                 && cfg_i.analog_select != 4'hA && cfg_i.analog_gain == 8'h64;
   assign ao_u = aa == 16'h8000 && cfg_i.analog_select == 4'hA;
   // cycles since reset release, saturating
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) up_reg <= 32'h0000_0000;
      else if (up_reg < SUPPLY_CYCLES) up_reg <= up_reg + 32'h0000_0001;
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);
   chk_relay_mode_zero: assert property ($past(rstn_i) && !$past(cfg_i.relay_mode)
      |-> fault_relay_o == $past(fault_i)) else $error("relay does not follow fault");
   chk_relay_fault_drop: assert property ($past(cfg_i.relay_mode) && $past(fault_i)
      |-> !fault_relay_o) else $error("relay held on fault in mode 1");
   chk_relay_supply_wait: assert property ($past(cfg_i.relay_mode)
      && up_reg < SUPPLY_CYCLES |-> !fault_relay_o) else $error("relay excited too early");
   chk_relay_reset_rest: assert property ($rose(rstn_i) |-> !fault_relay_o)
      else $error("relay excited at power up");
   chk_pulse_full_duty: assert property ($past(full_d) && $past(full_d, 2)
      && $past(rstn_i, 2) |-> pulse_monitor_pin_o) else $error("pulse not full duty");
   chk_pulse_zero_duty: assert property ($past(zero_d) && $past(zero_d, 2)
      |-> !pulse_monitor_pin_o) else $error("pulse high at zero amount");
   chk_analog_zero_out: assert property ($past(ao_z) && $past(ao_z, 2)
      |-> analog_monitor_pin_o == 12'h000) else $error("analog drive not zero");
   chk_analog_full_out: assert property ($past(ao_f) && $past(ao_f, 2) && $past(rstn_i, 2)
      |-> analog_monitor_pin_o == 12'h7FF) else $error("analog drive wrong at full");
   chk_analog_universal_full: assert property ($past(ao_u) && $past(ao_u, 2) && $past(rstn_i, 2)
      |-> analog_monitor_pin_o == 12'hFFF) else $error("universal drive wrong at full");
endmodule
bind monitor_pulse_and_fault_relay_output monitor_out_props #(
   .SUPPLY_CYCLES(SUPPLY_CYCLES)
) monitor_out_props_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .cfg_i(cfg_i),
   .monitor_amount_i(monitor_amount_i), .regenerating_i(regenerating_i), .fault_i(fault_i),
   .pulse_monitor_pin_o(pulse_monitor_pin_o), .analog_monitor_pin_o(analog_monitor_pin_o),
   .fault_relay_o(fault_relay_o));

//--- sim/pulse_meter.sv
// pulse counter and relay contact model at the far side of the stage
// assumes the pulse line is sampled on the core clock
`timescale 1ns/1ps
module pulse_meter (
   input  wire logic core_clk_i,
   input  wire logic pulse_i,
   input  wire logic relay_i,
   output int        period_o,
   output int        high_o,
   output logic      relay_open_contact_o,
   output logic      relay_closed_contact_o
);
   int   cnt = 0;
   logic last = 1'b0;
   // rise to rise gives the period, rise to fall the high time
   always @(posedge core_clk_i) begin
      cnt <= cnt + 1;
      last <= pulse_i;
      if (pulse_i && !last) period_o <= cnt;
      if (pulse_i && !last) cnt <= 1;
      if (!pulse_i && last) high_o <= cnt;
   end
   assign relay_open_contact_o = relay_i;
   assign relay_closed_contact_o = !relay_i;
endmodule

//--- sim/monitor_pulse_and_fault_relay_output_tb_top.sv
// self-checking bench for the monitor output stage
// assumes a 200 MHz clock and a short supply delay of 20 cycles
`timescale 1ns/1ps
module monitor_pulse_and_fault_relay_output_tb_top;
   logic                  core_clk_i = 1'b0;
   logic                  rstn_i = 1'b0;
   monitor_out_pkg::cfg_s cfg = '0;
   logic [10:0][15:0]     amt = '0;
   logic                  regen = 1'b0;
   logic                  fault = 1'b0;
   logic                  pulse;
   logic [11:0]           ao;
   logic                  relay;
   logic                  open_c;
   logic                  closed_c;
   int                    period;
   int                    high_t;
   int                    fail_count = 0;
   int                    checks_done = 0;
   int                    i;
   int                    rises;
   logic                  prev;
   always #2.5 core_clk_i = ~core_clk_i;
   monitor_pulse_and_fault_relay_output #(.SUPPLY_CYCLES(20))
      monitor_pulse_and_fault_relay_output_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
      .cfg_i(cfg), .monitor_amount_i(amt), .regenerating_i(regen), .fault_i(fault),
      .pulse_monitor_pin_o(pulse), .analog_monitor_pin_o(ao), .fault_relay_o(relay));
   pulse_meter pulse_meter_i (.core_clk_i(core_clk_i), .pulse_i(pulse), .relay_i(relay),
      .period_o(period), .high_o(high_t), .relay_open_contact_o(open_c),
      .relay_closed_contact_o(closed_c));
   task step(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (exp !== got) begin
         fail_count++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task relay_scenario;
      for (i = 0; i < 18; i++) begin
         step(1);
         chk("relay early", 1'b0, relay);
      end
      for (i = 0; i < 40 && relay !== 1'b1; i++) step(1);
      chk("relay mode 1 normal", 1'b1, relay);
      if (relay !== 1'b1) stop_test();
      fault = 1'b1;
      step(1);
      chk("closed contact on fault", 1'b1, closed_c);
      cfg.relay_mode = 1'b0;
      step(2);
      chk("relay mode 0 fault", 1'b1, relay);
      fault = 1'b0;
      step(1);
      chk("relay mode 0 normal", 1'b0, relay);
   endtask
   task analog_scenario;
      amt = {11{16'h8000}};
      cfg.analog_gain = 8'h64;
      for (i = 0; i < 11; i++) begin
         cfg.analog_select = 4'(i);
         step(2);
         if (i != 6) chk("analog full", (i == 10) ? 12'hFFF : 12'h7FF, ao);
      end
      cfg.analog_gain = 8'h00;
      step(2);
      chk("universal ignores gain", 12'hFFF, ao);
      cfg.analog_select = 4'h2;
      step(2);
      chk("gain zero", 12'h000, ao);
      cfg.analog_gain = 8'h64;
      amt[2] = 16'hFFFF;
      step(2);
      chk("analog clamp", 12'h7FF, ao);
      cfg.analog_select = 4'h6;
      amt[6] = 16'h4000;
      step(2);
      chk("power shown", 1'b1, ao != 12'h000);
      regen = 1'b1;
      step(2);
      chk("power on regen", 12'h000, ao);
   endtask
   task pulse_select_scenario;
      regen = 1'b0;
      cfg.pulse_avg = 8'hC8;
      for (i = 0; i < 11; i++) begin
         amt = {11{16'h8000}};
         amt[6] = 16'h4000;
         amt[i] = 16'h0000;
         cfg.pulse_select = 4'(i);
         step(3);
         chk("pulse zero amount", 1'b0, pulse);
         amt[i] = 16'h8000;
         step(3);
         chk("pulse full duty", 1'b1, pulse);
      end
   endtask
   task pulse_rate_scenario;
      regen = 1'b0;
      cfg.pulse_avg = 8'h00;
      cfg.pulse_rate = 13'h1770;
      cfg.pulse_select = 4'h0;
      amt[0] = 16'hFFFF;
      step(2);
      rises = 0;
      prev = pulse;
      for (i = 0; i < 70000 && rises < 2; i++) begin
         step(1);
         if (pulse === 1'b1 && prev === 1'b0) rises++;
         prev = pulse;
      end
      if (rises < 2) begin
         fail_count++;
         $display("MISMATCH pulse rises expected 2 seen %0d", rises);
         stop_test();
      end
      step(2);
      chk("pulse period", 1'b1, period inside {[33333:33334]});
      chk("pulse high time", 1'b1, high_t inside {[16666:16667]});
   endtask
   initial begin
      cfg.relay_mode = 1'b1;
      step(3);
      rstn_i = 1'b1;
      relay_scenario();
      analog_scenario();
      pulse_select_scenario();
      pulse_rate_scenario();
      rstn_i = 1'b0;
      step(1);
      chk("relay in reset", 1'b0, relay);
      stop_test();
   end
endmodule
